//--- core/cbd_exec.sv
// execution unit for compare-skip-less, decimal adjust and decrement-register
// Summary of operation
// - 0110 000a ffff ffff decodes as compare-skip-less; bit 8 window, low byte address.
// - compare register with accumulator unsigned; no result written, flags untouched.
// - register below accumulator: drop fetched instruction, run a no-op cycle instead.
// - one cycle, two when skipping, three when skipped instruction has two words.
// - window bit 0 uses fixed access bank; 1 uses bank pointer.
// - low nibble above 9 or half carry set: add 6 to low nibble.
// - high nibble above 9 or carry set: add 6 to high nibble.
// - decimal adjust changes only carry and half carry; carry may be set.
// - 0x0007 is decimal adjust; read accumulator phase two, write phase four; here it is read in phase four.
// - 0000 01da ffff ffff is decrement; bit 9 target, bit 8 window, one cycle.
// - decrement gives register minus one; target 0 accumulator, 1 register.
// - decrement updates carry, half carry, sign, wrap and zero from result.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "cbd_defines.svh"
module cbd_exec (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic next_is_two_word,
  output logic flush_fetch,
  output logic nop_cycle,
  output logic [11:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);
  import cbd_pkg::*;

  cbd_phase_e ph_r;
  cbd_op_e op_r;
  logic [7:0] acc_r;
  logic [4:0] status_r;
  logic [3:0] bank_r;
  logic [1:0] nop_cnt_r;
  logic lt_r;
  logic dest_r;
  logic [7:0] res_r;
  logic [4:0] dec_flags_r;
  logic flush_r;
  logic [11:0] mem_addr_r;
  logic mem_rd_r;
  logic mem_we_r;
  logic [7:0] mem_wdata_r;
  logic [7:0] reg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire accept = (ph_r == PH_Q1) && (nop_cnt_r == 2'h0) && instr_valid;
  wire is_cmp = (instr[15:9] == `CBD_CMP_PAT);
  wire is_daw = (instr == `CBD_DAW_OP);
  wire is_dec = (instr[15:10] == `CBD_DEC_PAT);
  wire cbd_op_e dec_op = is_cmp ? OP_CMP : is_daw ? OP_DAW : is_dec ? OP_DEC : OP_NONE;
  // window bit picks the access bank or the bank pointer
  wire [3:0] win_bank = instr[`CBD_BIT_WIN] ? bank_r : `CBD_ACCESS_BANK;
  wire needs_mem = is_cmp || is_dec;

  ////////////////////////////////////////////////////////////////////////////
  // datapath
  wire reg_lt = (mem_rdata < acc_r);
  wire [7:0] dec_res = mem_rdata - 8'h01;
  wire dec_c = (mem_rdata != 8'h00);
  wire dec_dc = (mem_rdata[3:0] != 4'h0);
  wire dec_ov = (mem_rdata == 8'h80);
  wire [4:0] dec_flags = {dec_res[7], dec_ov, (dec_res == 8'h00), dec_dc, dec_c};
  // high fix tests the unadjusted high nibble, so a digit carried in by the low fix is not caught
  wire lo_fix = (acc_r[3:0] > `CBD_BCD_LIMIT) || status_r[`CBD_FLAG_DC];
  wire hi_fix = (acc_r[7:4] > `CBD_BCD_LIMIT) || status_r[`CBD_FLAG_C];
  wire [8:0] daw_s1 = {1'b0, acc_r} + {5'h00, (lo_fix ? `CBD_BCD_FIX : 4'h0)};
  wire [8:0] daw_s2 = daw_s1 + {1'b0, (hi_fix ? `CBD_BCD_FIX : 4'h0), 4'h0};
  wire daw_dc = lo_fix && ({1'b0, acc_r[3:0]} + {1'b0, `CBD_BCD_FIX} > 5'h0F);
  wire daw_c = daw_s2[8] || status_r[`CBD_FLAG_C];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_acc = reg_we && (reg_addr == `CBD_OFF_ACC);
  wire wr_status = reg_we && (reg_addr == `CBD_OFF_STATUS);
  wire wr_bank = reg_we && (reg_addr == `CBD_OFF_BANK);
  wire [7:0] exec_view = {3'h0, lt_r, nop_cnt_r, ph_r};
  wire [7:0] rd_mux = (reg_addr == `CBD_OFF_ACC) ? acc_r :
                      (reg_addr == `CBD_OFF_STATUS) ? {3'h0, status_r} :
                      (reg_addr == `CBD_OFF_BANK) ? {4'h0, bank_r} :
                      (reg_addr == `CBD_OFF_EXEC) ? exec_view : 8'h00;
  wire q4 = (ph_r == PH_Q4);
  wire exec_acc = q4 && ((op_r == OP_DAW) || ((op_r == OP_DEC) && !dest_r));
  wire exec_flags = q4 && ((op_r == OP_DAW) || (op_r == OP_DEC));

  assign instr_ready = (ph_r == PH_Q1) && (nop_cnt_r == 2'h0);
  assign flush_fetch = flush_r;
  assign nop_cycle = (nop_cnt_r != 2'h0);
  assign mem_addr = mem_addr_r;
  assign mem_rd = mem_rd_r;
  assign mem_we = mem_we_r;
  assign mem_wdata = mem_wdata_r;
  assign reg_rdata = reg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ph_r <= PH_Q1;
    end else begin
      case (ph_r)
        PH_Q1: ph_r <= PH_Q2;
        PH_Q2: ph_r <= PH_Q3;
        PH_Q3: ph_r <= PH_Q4;
        PH_Q4: ph_r <= PH_Q1;
        default: ph_r <= PH_Q1;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      op_r <= OP_NONE;
      dest_r <= 1'b0;
      mem_addr_r <= 12'h000;
    end else if (ph_r == PH_Q1) begin
      op_r <= accept ? dec_op : OP_NONE;
      dest_r <= instr[`CBD_BIT_DEST];
      mem_addr_r <= {win_bank, instr[7:0]};
    end
  end

  // memory read in Q2, data returns in Q3
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_rd_r <= 1'b0;
    end else begin
      mem_rd_r <= accept && needs_mem;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lt_r <= 1'b0;
      res_r <= 8'h00;
      dec_flags_r <= 5'h00;
    end else if (ph_r == PH_Q3) begin
      lt_r <= (op_r == OP_CMP) && reg_lt;
      res_r <= dec_res;
      dec_flags_r <= dec_flags;
    end
  end

  // register-destination write strobe stands in Q4
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_we_r <= 1'b0;
      mem_wdata_r <= 8'h00;
    end else begin
      mem_we_r <= (ph_r == PH_Q3) && (op_r == OP_DEC) && dest_r;
      mem_wdata_r <= (ph_r == PH_Q3) ? dec_res : mem_wdata_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip control
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nop_cnt_r <= 2'h0;
      flush_r <= 1'b0;
    end else begin
      flush_r <= q4 && (op_r == OP_CMP) && lt_r;
      if (q4 && (nop_cnt_r != 2'h0)) begin
        nop_cnt_r <= nop_cnt_r - 2'h1;
      end else if (q4 && (op_r == OP_CMP) && lt_r) begin
        nop_cnt_r <= next_is_two_word ? `CBD_NOP_TWO : `CBD_NOP_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // architectural state; execution wins over a same-cycle bus write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_r <= `CBD_RST_ACC;
    end else if (exec_acc) begin
      acc_r <= (op_r == OP_DAW) ? daw_s2[7:0] : res_r;
    end else if (wr_acc) begin
      acc_r <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_r <= `CBD_RST_STATUS;
    end else if (exec_flags && (op_r == OP_DAW)) begin
      status_r <= {status_r[4:2], daw_dc, daw_c};
    end else if (exec_flags) begin
      status_r <= dec_flags_r;
    end else if (wr_status) begin
      status_r <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bank_r <= `CBD_RST_BANK;
      reg_rdata_r <= 8'h00;
    end else begin
      bank_r <= wr_bank ? reg_wdata[3:0] : bank_r;
      reg_rdata_r <= reg_re ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_cmp_end;
    (ph_r == PH_Q4) && (op_r == OP_CMP);
  endsequence

  sequence s_dec_q3;
    (ph_r == PH_Q3) && (op_r == OP_DEC);
  endsequence

  a_cmp_decode: assert property (@(posedge ref_clk) disable iff (rst)
    accept && is_cmp |=> (op_r == OP_CMP) && mem_rd_r)
    else $error("compare opcode not decoded");

  a_cmp_flags_hold: assert property (@(posedge ref_clk) disable iff (rst)
    s_cmp_end |=> $stable(status_r) && !mem_we_r)
    else $error("compare changed flags or wrote memory");

  a_skip_flush: assert property (@(posedge ref_clk) disable iff (rst)
    s_cmp_end and lt_r |=> flush_fetch && nop_cycle ##1 (nop_cycle && !flush_fetch) [*3])
    else $error("skip did not flush and idle");

  a_skip_two_word: assert property (@(posedge ref_clk) disable iff (rst)
    s_cmp_end and lt_r and next_is_two_word |=> nop_cycle [*8] ##1 !nop_cycle)
    else $error("two-word skip length wrong");

  a_no_skip: assert property (@(posedge ref_clk) disable iff (rst)
    s_cmp_end and !lt_r |=> !nop_cycle && !flush_fetch)
    else $error("skip taken without cause");

  a_bank_select: assert property (@(posedge ref_clk) disable iff (rst)
    accept && needs_mem |=> mem_addr_r[11:8] ==
      ($past(instr[`CBD_BIT_WIN]) ? $past(bank_r) : `CBD_ACCESS_BANK))
    else $error("wrong bank for operand");

  a_daw_low: assert property (@(posedge ref_clk) disable iff (rst)
    q4 && (op_r == OP_DAW) && (acc_r[3:0] > 4'h9) |=>
      acc_r[3:0] == $past(acc_r[3:0]) + 4'h6)
    else $error("low nibble not adjusted");

  a_daw_high: assert property (@(posedge ref_clk) disable iff (rst)
    q4 && (op_r == OP_DAW) && (acc_r[7:4] <= 4'h9) && (acc_r[3:0] <= 4'h9) &&
      !status_r[`CBD_FLAG_C] && !status_r[`CBD_FLAG_DC] |=>
      $stable(acc_r))
    else $error("valid bcd value changed");

  a_daw_flags: assert property (@(posedge ref_clk) disable iff (rst)
    q4 && (op_r == OP_DAW) && (acc_r[7:4] > 4'h9) |=>
      status_r[`CBD_FLAG_C] && (status_r[4:2] == $past(status_r[4:2])))
    else $error("adjust flags wrong");

  a_daw_decode: assert property (@(posedge ref_clk) disable iff (rst)
    accept && is_daw |=> (op_r == OP_DAW) && !mem_rd_r ##2 (ph_r == PH_Q4))
    else $error("adjust opcode not decoded");

  a_dec_mem: assert property (@(posedge ref_clk) disable iff (rst)
    s_dec_q3 and dest_r |=> mem_we_r && (mem_wdata_r == $past(mem_rdata) - 8'h01))
    else $error("decrement register write wrong");

  a_dec_acc: assert property (@(posedge ref_clk) disable iff (rst)
    s_dec_q3 and !dest_r |=> !mem_we_r ##1 (acc_r == $past(mem_rdata, 2) - 8'h01))
    else $error("decrement accumulator write wrong");

  a_dec_zero: assert property (@(posedge ref_clk) disable iff (rst)
    s_dec_q3 and (mem_rdata == 8'h01) |=> ##1 status_r[`CBD_FLAG_Z] && status_r[`CBD_FLAG_C])
    else $error("decrement of one did not set zero");

endmodule
`default_nettype wire

//--- shared/cbd_defines.svh
// offsets, field positions, opcodes and reset values for the compare/adjust/decrement unit
`ifndef CBD_DEFINES_SVH
`define CBD_DEFINES_SVH
`define CBD_OFF_ACC 4'h0
`define CBD_OFF_STATUS 4'h4
`define CBD_OFF_BANK 4'h8
`define CBD_OFF_EXEC 4'hC
`define CBD_FLAG_C 0
`define CBD_FLAG_DC 1
`define CBD_FLAG_Z 2
`define CBD_FLAG_OV 3
`define CBD_FLAG_N 4
`define CBD_BIT_DEST 9
`define CBD_BIT_WIN 8
`define CBD_CMP_PAT 7'h30
`define CBD_DAW_OP 16'h0007
`define CBD_DEC_PAT 6'h01
`define CBD_ACCESS_BANK 4'h0
`define CBD_BCD_LIMIT 4'h9
`define CBD_BCD_FIX 4'h6
`define CBD_NOP_ONE 2'h1
`define CBD_NOP_TWO 2'h2
`define CBD_RST_ACC 8'h00
`define CBD_RST_STATUS 5'h00
`define CBD_RST_BANK 4'h0
`endif

//--- shared/cbd_pkg.sv
// types for the compare/adjust/decrement unit
package cbd_pkg;
  typedef enum logic [1:0] {OP_NONE, OP_CMP, OP_DAW, OP_DEC} cbd_op_e;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cbd_phase_e;
endpackage

//--- verification/tb_compare_bcd_decrement_exec.sv
// self-checking testbench for the compare/adjust/decrement execution unit
`timescale 1ns/10ps
`default_nettype none
module tb_compare_bcd_decrement_exec;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic next_is_two_word = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic instr_ready, flush_fetch, nop_cycle, mem_rd, mem_we, rd_s, we_s;
  logic [11:0] mem_addr, addr_s;
  logic [7:0] mem_wdata, reg_rdata, wd_s, rv;
  logic [1:0] ph = 2'h0;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;

  cbd_exec uut (.ref_clk(ref_clk), .rst(rst), .instr(instr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .next_is_two_word(next_is_two_word), .flush_fetch(flush_fetch),
    .nop_cycle(nop_cycle), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  always #5 ref_clk = ~ref_clk;
  // own phase count, so every instruction is offered on a q1 edge
  always @(posedge ref_clk) ph <= rst ? 2'h0 : ph + 2'h1;
  // ceiling far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // idle cycle after the strobe so back-to-back calls never drive it twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge ref_clk);
    reg_we <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    @(posedge ref_clk);
    rv = reg_rdata;
  endtask

  // values read at an edge are those of the cycle that edge ends
  task automatic run(input logic [15:0] op, input logic [7:0] f, input logic tw);
    while (ph != 2'h3) @(posedge ref_clk);
    instr <= op;
    instr_valid <= 1'b1;
    mem_rdata <= f;
    next_is_two_word <= tw;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    @(posedge ref_clk);
    rd_s = mem_rd;
    addr_s = mem_addr;
    repeat (2) @(posedge ref_clk);
    we_s = mem_we;
    wd_s = mem_wdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wr(4'h2, 8'hFF);
    for (int a = 0; a < 4; a++) begin
      rd(4'(a * 4 + (a == 3 ? -10 : 0)));
      chk(rv, 12'h000);
    end
  endtask

  task automatic t_cmp_equal();
    wr(4'h8, 8'h05);
    wr(4'h0, 8'h50);
    wr(4'h4, 8'h1F);
    run(16'h613C, 8'h50, 1'b0);
    chk(rd_s, 1'b1);
    chk(addr_s, 12'h53C);
    chk(we_s, 1'b0);
    @(posedge ref_clk);
    chk(flush_fetch | nop_cycle, 1'b0);
    rd(4'h4);
    chk(rv, 12'h01F);
    rd(4'h0);
    chk(rv, 12'h050);
  endtask

  task automatic t_skip(input logic tw, input logic [11:0] exp);
    logic [11:0] nops = 12'h000;
    logic [11:0] fl = 12'h000;
    logic [11:0] wrs = 12'h000;
    run(16'h603C, 8'h4F, tw);
    chk(addr_s, 12'h03C);
    // a decrement offered while the no-ops run must be refused
    instr <= 16'h063C;
    instr_valid <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge ref_clk);
      if (i == 0) chk(instr_ready, 1'b0);
      if (i == 3) instr_valid <= 1'b0;
      nops += nop_cycle;
      fl += flush_fetch;
      wrs += mem_we;
    end
    chk(nops, exp);
    chk(fl, 12'h001);
    chk(wrs, 12'h000);
  endtask

  task automatic t_daw();
    logic [7:0] t [4][4] = '{'{8'hA5, 8'h1C, 8'h05, 8'h1D}, '{8'hCE, 8'h1C, 8'h34, 8'h1F},
      '{8'h12, 8'h1F, 8'h78, 8'h1D}, '{8'h99, 8'h1C, 8'h99, 8'h1C}};
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, t[i][0]);
      wr(4'h4, t[i][1]);
      run(16'h0007, 8'h00, 1'b0);
      chk(rd_s | we_s, 1'b0);
      rd(4'h0);
      chk(rv, t[i][2]);
      rd(4'h4);
      chk(rv, t[i][3]);
    end
  endtask

  task automatic t_dec();
    logic [15:0] op [4] = '{16'h053C, 16'h063C, 16'h073C, 16'h043C};
    logic [7:0] v [4][3] = '{'{8'h01, 8'h00, 8'h07}, '{8'h00, 8'hFF, 8'h10},
      '{8'h80, 8'h7F, 8'h09}, '{8'h10, 8'h0F, 8'h01}};
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, 8'h00);
      wr(4'h0, 8'hAA);
      run(op[i], v[i][0], 1'b0);
      chk(rd_s, 1'b1);
      chk(addr_s, {op[i][8] ? 4'h5 : 4'h0, op[i][7:0]});
      chk(we_s, op[i][9]);
      if (op[i][9]) chk(wd_s, v[i][1]);
      rd(4'h0);
      chk(rv, op[i][9] ? 8'hAA : v[i][1]);
      rd(4'h4);
      chk(rv, v[i][2]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_cmp_equal();
    t_skip(1'b0, 12'h004);
    t_skip(1'b1, 12'h008);
    t_daw();
    t_dec();
    wrap_up();
  end
endmodule
`default_nettype wire
